// ### rtl/smb_regs.svh
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
`define SMB_ADDR_HI    5'h0B
`define SMB_REG_LAST   8'hEF
`define SMB_REG_MAX    8'hFF
`define SMB_CMD_BLKW   8'hF0
`define SMB_CMD_PCALL  8'hF1
`define SMB_FIX_F2_A   8'h40
`define SMB_FIX_F2_N   6'h08
`define SMB_FIX_F3_A   8'h48
`define SMB_FIX_F3_N   6'h08
`define SMB_FIX_F4_A   8'h50
`define SMB_FIX_F4_N   6'h06
`define SMB_FIX_F5_A   8'h56
`define SMB_FIX_F5_N   6'h10
`define SMB_FIX_F6_A   8'h67
`define SMB_FIX_F6_N   6'h04
`define SMB_FIX_F7_A   8'h6E
`define SMB_FIX_F7_N   6'h08
`define SMB_FIX_F8_A   8'h78
`define SMB_FIX_F8_N   6'h0C
`define SMB_FIX_F9_A   8'h90
`define SMB_FIX_F9_N   6'h20
`define SMB_FIX_FA_A   8'hB4
`define SMB_FIX_FA_N   6'h08
`define SMB_FIX_FB_A   8'hC8
`define SMB_FIX_FB_N   6'h08
`define SMB_FIX_FC_A   8'hD0
`define SMB_FIX_FC_N   6'h10
`define SMB_FIX_FD_A   8'hE5
`define SMB_FIX_FD_N   6'h09
`define SMB_TMO_US     25000
`define SMB_LINK_KHZ   8000
`define SMB_TMO_CYC    (`SMB_TMO_US * `SMB_LINK_KHZ / 1000)
`endif

// ### rtl/smb_pkg.sv
`default_nettype none
package smb_pkg;
    typedef enum logic [1:0] {OP_WR = 2'b00, OP_RD = 2'b01} smb_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_WBYTE = 3'b010, ST_RBYTE = 3'b011,
        ST_SACK = 3'b100, ST_MACK = 3'b101, ST_IGN = 3'b110
    } smb_st_t;
    typedef enum logic [1:0] {MD_NORM = 2'b00, MD_BLK = 2'b01, MD_FIX = 2'b10} smb_md_t;
    typedef enum logic [1:0] {SP_IDLE = 2'b00, SP_ISSUE = 2'b01, SP_TAKE = 2'b10} smb_sp_t;
    typedef struct packed {
        smb_op_t    op;
        logic       commit;
        logic [7:0] addr;
        logic [7:0] data;
    } smb_ev_t;
    typedef struct packed {
        logic        rs1, rs2, scl1, scl2, sclp, sda1, sda2, sdap;
        logic [1:0]  sel1, sel2;
        logic        ack1, ack2, ackp;
        smb_st_t     st;
        logic [3:0]  cnt;
        logic [7:0]  sh, nxt, base, ptr;
        logic        rd, nxt_reg, cur_reg, f1, locked, oe, sdo, req;
        smb_md_t     mode;
        logic [1:0]  widx, lat;
        logic [5:0]  bcnt, wcnt;
        logic [23:0] tmo;
        smb_ev_t     ev;
    } smb_lnk_t;
    typedef struct packed {
        logic       req1, req2, reqp, ack, wr, rd, done;
        smb_sp_t    ph;
        smb_ev_t    ev;
        logic [7:0] addr, wdata, rdata, last;
    } smb_sys_t;
endpackage
`default_nettype wire

// ### rtl/smb_slave.sv
`include "smb_regs.svh"
`default_nettype none
module smb_slave
    import smb_pkg::*;
#(
    parameter int TIMEOUT_CYC = `SMB_TMO_CYC
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       link_clk,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [1:0] addr_sel,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            reg_rd_done,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rd_data
);
    smb_lnk_t q, n;
    smb_sys_t s, m;
    logic     lrst_n, start_w, stop_w, rise_w, fall_w, low_w, tmo_w, blk_w;
    logic [7:0] b;
    logic [13:0] fx;

    function automatic logic [13:0] fix_of(input logic [7:0] c);
        unique case (c)
            8'hF2:   fix_of = {`SMB_FIX_F2_A, `SMB_FIX_F2_N};
            8'hF3:   fix_of = {`SMB_FIX_F3_A, `SMB_FIX_F3_N};
            8'hF4:   fix_of = {`SMB_FIX_F4_A, `SMB_FIX_F4_N};
            8'hF5:   fix_of = {`SMB_FIX_F5_A, `SMB_FIX_F5_N};
            8'hF6:   fix_of = {`SMB_FIX_F6_A, `SMB_FIX_F6_N};
            8'hF7:   fix_of = {`SMB_FIX_F7_A, `SMB_FIX_F7_N};
            8'hF8:   fix_of = {`SMB_FIX_F8_A, `SMB_FIX_F8_N};
            8'hF9:   fix_of = {`SMB_FIX_F9_A, `SMB_FIX_F9_N};
            8'hFA:   fix_of = {`SMB_FIX_FA_A, `SMB_FIX_FA_N};
            8'hFB:   fix_of = {`SMB_FIX_FB_A, `SMB_FIX_FB_N};
            8'hFC:   fix_of = {`SMB_FIX_FC_A, `SMB_FIX_FC_N};
            8'hFD:   fix_of = {`SMB_FIX_FD_A, `SMB_FIX_FD_N};
            default: fix_of = 14'h0000;
        endcase
    endfunction
    function automatic logic [7:0] sat_inc(input logic [7:0] a);
        sat_inc = (a == `SMB_REG_MAX) ? `SMB_REG_MAX : a + 8'h01;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: bus sampling and protocol engine
    assign lrst_n  = q.rs2;
    assign start_w = q.scl2 & q.sclp & q.sdap & ~q.sda2;
    assign stop_w  = q.scl2 & q.sclp & ~q.sdap & q.sda2;
    assign rise_w  = q.scl2 & ~q.sclp;
    assign fall_w  = ~q.scl2 & q.sclp;
    assign low_w   = ~q.scl2 | ~q.sda2;
    assign tmo_w   = low_w & (q.tmo == 24'(TIMEOUT_CYC - 1));
    assign blk_w   = (q.mode == MD_FIX) | ((q.mode == MD_BLK) & q.f1);
    assign b       = {q.sh[6:0], q.sda2};
    assign fx      = fix_of(b);

    always_comb begin
        n      = q;
        n.rs1  = nrst;
        n.rs2  = q.rs1;
        n.scl1 = scl_i;
        n.scl2 = q.scl1;
        n.sclp = q.scl2;
        n.sda1 = sda_i;
        n.sda2 = q.sda1;
        n.sdap = q.sda2;
        n.sel1 = addr_sel;
        n.sel2 = q.sel1;
        n.ack1 = s.ack;
        n.ack2 = q.ack1;
        n.ackp = q.ack2;
        n.sdo  = 1'b0;
        n.tmo  = (low_w && !tmo_w) ? q.tmo + 24'h000001 : 24'h000000;
        if (q.ack2 != q.ackp) begin
            n.nxt = s.rdata;
        end
        if (start_w) begin
            n.st  = ST_ADDR;
            n.cnt = 4'h0;
            n.oe  = 1'b0;
        end else if (stop_w || tmo_w) begin
            n.st = ST_IDLE;
            n.oe = 1'b0;
        end else if (rise_w) begin
            unique case (q.st)
                ST_ADDR, ST_WBYTE: begin
                    n.sh  = b;
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        n.st  = ST_SACK;
                        n.cnt = 4'h0;
                        if (q.st == ST_ADDR) begin
                            if (b[7:3] == `SMB_ADDR_HI
                                && b[2:1] == (q.locked ? q.lat : q.sel2)) begin
                                n.locked = 1'b1;
                                n.lat    = q.locked ? q.lat : q.sel2;
                                n.rd     = b[0];
                                n.widx   = 2'h0;
                                n.ptr    = q.base;
                                if (b[0] && blk_w) begin
                                    n.nxt     = {2'h0, (q.mode == MD_FIX) ? q.bcnt : q.wcnt};
                                    n.nxt_reg = 1'b0;
                                end else if (b[0]) begin
                                    n.req     = ~q.req;
                                    n.ev      = '{OP_RD, 1'b0, q.base, 8'h00};
                                    n.ptr     = sat_inc(q.base);
                                    n.nxt_reg = 1'b1;
                                end
                            end else begin
                                n.st = ST_IGN;
                            end
                        end else begin
                            n.widx = (q.widx == 2'h3) ? 2'h3 : q.widx + 2'h1;
                            if (q.widx == 2'h0) begin
                                if (b == `SMB_CMD_BLKW || b == `SMB_CMD_PCALL) begin
                                    n.mode = MD_BLK;
                                    n.f1   = b[0];
                                    n.wcnt = 6'h00;
                                end else if (fx != 14'h0000) begin
                                    n.mode = MD_FIX;
                                    n.base = fx[13:6];
                                    n.bcnt = fx[5:0];
                                end else begin
                                    n.mode = MD_NORM;
                                    n.base = b;
                                    n.ptr  = b;
                                end
                            end else if (q.mode == MD_BLK && q.widx == 2'h1) begin
                                n.wcnt = 6'h00;
                            end else if (q.mode == MD_BLK && q.widx == 2'h2) begin
                                n.base = b;
                                n.ptr  = b;
                            end else if (q.mode != MD_FIX) begin
                                n.ptr = sat_inc(q.ptr);
                                if (q.mode == MD_BLK) begin
                                    n.wcnt = q.wcnt + 6'h01;
                                end
                                if (q.ptr <= `SMB_REG_LAST) begin
                                    n.req = ~q.req;
                                    n.ev  = '{OP_WR, 1'b0, q.ptr, b};
                                end
                            end
                        end
                    end
                end
                ST_RBYTE: begin
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        n.req     = ~q.req;
                        n.ev      = '{OP_RD, q.cur_reg, q.ptr, 8'h00};
                        n.ptr     = sat_inc(q.ptr);
                        n.nxt_reg = 1'b1;
                    end
                end
                ST_MACK: begin
                    if (q.sda2) begin
                        n.st = ST_IGN;
                    end
                end
                default: begin
                end
            endcase
        end else if (fall_w) begin
            unique case (q.st)
                ST_SACK: begin
                    if (q.cnt == 4'h0) begin
                        n.oe  = 1'b1;
                        n.cnt = 4'h1;
                    end else begin
                        n.cnt = 4'h0;
                        n.st  = q.rd ? ST_RBYTE : ST_WBYTE;
                        n.oe  = q.rd & ~q.nxt[7];
                        n.sh  = q.nxt;
                        n.cur_reg = q.nxt_reg;
                    end
                end
                ST_RBYTE: begin
                    if (q.cnt == 4'h8) begin
                        n.oe = 1'b0;
                        n.st = ST_MACK;
                    end else begin
                        n.sh = {q.sh[6:0], 1'b0};
                        n.oe = ~q.sh[6];
                    end
                end
                ST_MACK: begin
                    n.cnt     = 4'h0;
                    n.st      = ST_RBYTE;
                    n.sh      = q.nxt;
                    n.cur_reg = q.nxt_reg;
                    n.oe      = ~q.nxt[7];
                end
                default: begin
                end
            endcase
        end
    end

    // The device reset pin nrst reaches this domain through two link-clock flops (rs1, rs2)
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            q      <= '0;
            q.rs1  <= n.rs1;
            q.rs2  <= n.rs2;
            q.scl1 <= 1'b1;
            q.scl2 <= 1'b1;
            q.sclp <= 1'b1;
            q.sda1 <= 1'b1;
            q.sda2 <= 1'b1;
            q.sdap <= 1'b1;
        end else begin
            q <= n;
        end
    end
    assign sda_o  = q.sdo;
    assign sda_oe = q.oe;

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: register-side strobes
    always_comb begin
        m      = s;
        m.req1 = q.req;
        m.req2 = s.req1;
        m.reqp = s.req2;
        m.wr   = 1'b0;
        m.rd   = 1'b0;
        m.done = 1'b0;
        unique case (s.ph)
            SP_IDLE: begin
                if (s.req2 != s.reqp) begin
                    m.ev = q.ev;
                    m.ph = SP_ISSUE;
                    if (q.ev.commit) begin
                        m.done = 1'b1;
                        m.addr = s.last;
                    end
                end
            end
            SP_ISSUE: begin
                m.ph    = SP_TAKE;
                m.addr  = s.ev.addr;
                m.wdata = s.ev.data;
                m.wr    = (s.ev.op == OP_WR);
                m.rd    = (s.ev.op == OP_RD);
                if (s.ev.op == OP_RD) begin
                    m.last = s.ev.addr;
                end
            end
            SP_TAKE: begin
                m.ph  = SP_IDLE;
                m.ack = ~s.ack;
                if (s.rd) begin
                    m.rdata = reg_rd_data;
                end
            end
            default: begin
                m.ph = SP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= m;
        end
    end
    assign reg_wr      = s.wr;
    assign reg_rd      = s.rd;
    assign reg_rd_done = s.done;
    assign reg_addr    = s.addr;
    assign reg_wdata   = s.wdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_addr_done;
        rise_w && !start_w && !stop_w && !tmo_w && q.st == ST_ADDR && q.cnt == 4'h7;
    endsequence
    property p_start;
        @(posedge link_clk) disable iff (!lrst_n)
        start_w |=> q.st == ST_ADDR && q.cnt == 4'h0 && !q.oe;
    endproperty
    a_start: assert property (p_start) else $error("START not taken");
    property p_stop;
        @(posedge link_clk) disable iff (!lrst_n)
        stop_w && !start_w |=> q.st == ST_IDLE && !q.oe;
    endproperty
    a_stop: assert property (p_stop) else $error("STOP not taken");
    property p_nomatch;
        @(posedge link_clk) disable iff (!lrst_n)
        s_addr_done ##0 (b[7:3] != `SMB_ADDR_HI || (q.locked && b[2:1] != q.lat))
            |=> q.st == ST_IGN && !q.oe;
    endproperty
    a_nomatch: assert property (p_nomatch) else $error("foreign address answered");
    property p_ign_quiet;
        @(posedge link_clk) disable iff (!lrst_n)
        q.st == ST_IGN |-> !q.oe;
    endproperty
    a_ign_quiet: assert property (p_ign_quiet) else $error("data driven while idle");
    property p_ack_hold;
        @(posedge link_clk) disable iff (!lrst_n)
        q.st == ST_SACK && q.cnt == 4'h1 && q.scl2 |-> q.oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack not held in high");
    property p_tmo;
        @(posedge link_clk) disable iff (!lrst_n)
        tmo_w && !start_w |=> q.st == ST_IDLE && !q.oe && q.tmo == 24'h000000;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not honoured");
    property p_event_at_byte;
        @(posedge link_clk) disable iff (!lrst_n)
        ##1 $changed(q.req) |-> $past(rise_w) && $past(q.cnt) == 4'h7;
    endproperty
    a_event_at_byte: assert property (p_event_at_byte) else $error("partial byte used");
    property p_base_hold;
        @(posedge link_clk) disable iff (!lrst_n)
        ##1 $changed(q.base) |-> $past(q.st) == ST_WBYTE;
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("base moved");
    property p_fix_f9;
        @(posedge link_clk) disable iff (!lrst_n)
        rise_w && !start_w && !stop_w && !tmo_w && q.st == ST_WBYTE && q.cnt == 4'h7
            && q.widx == 2'h0 && b == 8'hF9
        |=> q.base == 8'h90 && q.bcnt == 6'h20 && q.mode == MD_FIX;
    endproperty
    a_fix_f9: assert property (p_fix_f9) else $error("fixed block F9 wrong");
    property p_wr_range;
        @(posedge clock) disable iff (!nrst)
        reg_wr |-> reg_addr <= `SMB_REG_LAST ##1 !reg_wr;
    endproperty
    a_wr_range: assert property (p_wr_range) else $error("write outside register space");
endmodule
`default_nettype wire

// ### sim/smb_host.sv
`default_nettype none
module smb_host (
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Half bit time in link cycles; 16 gives a slow host
    int         h = 8;
    logic [7:0] rx;
    event       rx_ev;

    // Bus idles high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge link_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // One clock pulse: data moves mid low phase, sampled mid high phase
    task automatic pulse(input logic b, output logic r);
        tick(h / 2);
        sda_low = ~b;
        tick(h / 2);
        scl = 1'b1;
        tick(h / 2);
        r = sda;
        tick(h / 2);
        scl = 1'b0;
    endtask

    // Works from idle and as a repeated start
    task automatic start();
        sda_low = 1'b0;
        tick(h);
        scl = 1'b1;
        tick(h);
        sda_low = 1'b1;
        tick(h);
        scl = 1'b0;
    endtask

    // Holds data low for n link cycles to provoke the low-line timeout
    task automatic hold_low(input int n);
        sda_low = 1'b1;
        tick(n);
    endtask

    task automatic stop();
        tick(h / 2);
        sda_low = 1'b1;
        tick(h / 2);
        scl = 1'b1;
        tick(h);
        sda_low = 1'b0;
        tick(h);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Sends n bits MSB first; a whole byte also clocks the ack slot
    task automatic put(input logic [7:0] b, input int n, output logic ack);
        logic r;
        for (int i = 7; i > 7 - n; i--) begin
            pulse(b[i], r);
        end
        ack = 1'b0;
        if (n == 8) begin
            pulse(1'b1, r);
            ack = ~r;
        end
    endtask

    // Receives n bits; NACK on the last byte of a read
    task automatic get(input int n, input logic ack);
        logic r;
        for (int i = 7; i > 7 - n; i--) begin
            pulse(1'b1, r);
            rx[i] = r;
        end
        if (n == 8) begin
            pulse(~ack, r);
            -> rx_ev;
        end
    endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMO = 1000;
    logic        clock    = 1'b0;
    logic        link_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic [1:0]  addr_sel = 2'b01;
    logic        scl;
    logic        sda_low;
    logic        sda_o;
    logic        sda_oe;
    logic        reg_wr;
    logic        reg_rd;
    logic        reg_rd_done;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rd_data;
    wire logic   sda;
    logic [7:0]  mem [256];
    logic [15:0] wq [$];
    logic [7:0]  rq [$];
    logic [6:0]  me;
    int          errors     = 0;
    int          n_compared = 0;
    int          n_done     = 0;
    int          n_rd       = 0;
    int          seed       = 82242;
    logic [1:0]  codes [3]  = '{2'b01, 2'b10, 2'b00};
    logic [7:0]  fa [12]    = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6E,
                                8'h78, 8'h90, 8'hB4, 8'hC8, 8'hD0, 8'hE5};
    logic [7:0]  fn [12]    = '{8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08,
                                8'h0C, 8'h20, 8'h08, 8'h08, 8'h10, 8'h09};

    // Open-drain data line with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    assign reg_rd_data = mem[reg_addr];

    initial forever #20 clock = ~clock;
    initial begin
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    smb_slave #(.TIMEOUT_CYC(TMO)) u_smb_slave (
        .clock(clock), .nrst(nrst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data)
    );
    smb_host u_smb_host (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register file model and result watchers
    always @(posedge clock) begin
        if (reg_wr === 1'b1) begin
            chk({reg_addr, reg_wdata}, wq.size() ? wq.pop_front() : 16'hXXXX);
            mem[reg_addr] <= reg_wdata;
        end
        if (reg_rd_done === 1'b1) begin
            n_done++;
        end
        if (reg_rd === 1'b1) begin
            n_rd++;
        end
    end
    always @(u_smb_host.rx_ev) begin
        chk({8'h00, u_smb_host.rx}, {8'h00, rq.size() ? rq.pop_front() : 8'hXX});
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd_a();
        return 8'($unsigned($random(seed)) % 240);
    endfunction

    task automatic do_reset(input logic [1:0] sel);
        nrst <= 1'b0;
        addr_sel <= sel;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (20) @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] b, input logic e);
        logic a;
        u_smb_host.put(b, 8, a);
        chk({15'h0000, a}, {15'h0000, e});
    endtask

    task automatic rd(input logic [7:0] exp, input logic ack);
        rq.push_back(exp);
        u_smb_host.get(8, ack);
    endtask

    task automatic setptr(input logic [7:0] a);
        u_smb_host.start();
        wr({me, 1'b0}, 1'b1);
        wr(a, 1'b1);
    endtask

    task automatic rdaddr();
        u_smb_host.start();
        wr({me, 1'b1}, 1'b1);
    endtask

    task automatic wseq(input logic [7:0] a, input int n);
        logic [7:0] d;
        setptr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            if (a + 8'(i) <= 8'hEF) wq.push_back({a + 8'(i), d});
            wr(d, 1'b1);
        end
    endtask

    // Count byte is deliberately wrong; address saturates at the top
    task automatic blk(input logic [7:0] cmd, input logic [7:0] s, input int n);
        logic [7:0] d;
        setptr(cmd);
        wr(8'h01, 1'b1);
        wr(s, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            if (s <= 8'hEF) wq.push_back({s, d});
            wr(d, 1'b1);
            if (s != 8'hFF) s++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        logic       k_ack;
        int         nd;
        int         nr;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($random(seed));
        end
        foreach (codes[k]) begin
            do_reset(codes[k]);
            me = {5'h0B, codes[k]};
            wseq(rnd_a(), 1);
            u_smb_host.stop();
        end
        @(posedge clock);
        addr_sel <= 2'b01;
        wseq(rnd_a(), 2);
        u_smb_host.stop();
        u_smb_host.start();
        wr({5'h0B, 2'b01, 1'b0}, 1'b0);
        wr(8'h10, 1'b0);
        u_smb_host.stop();
        // Send byte, then reads that never move the base
        a = rnd_a();
        setptr(a);
        u_smb_host.stop();
        repeat (2) begin
            rdaddr();
            rd(mem[a], 1'b0);
            u_smb_host.stop();
        end
        u_smb_host.h = 16;
        a = rnd_a();
        setptr(a);
        nd = n_done;
        nr = n_rd;
        rdaddr();
        rd(mem[a], 1'b1);
        rd(mem[a + 8'h01], 1'b0);
        u_smb_host.stop();
        chk(16'(n_done - nd), 16'h0002);
        chk(16'(n_rd - nr), 16'h0003);
        u_smb_host.h = 8;
        blk(8'hF0, 8'hEE, 4);
        u_smb_host.stop();
        blk(8'hF0, 8'hFE, 3);
        u_smb_host.stop();
        blk(8'hF1, 8'h30, 2);
        rdaddr();
        rd(8'h02, 1'b1);
        rd(mem[8'h30], 1'b1);
        rd(mem[8'h31], 1'b0);
        u_smb_host.stop();
        foreach (fa[k]) begin
            setptr(8'hF2 + 8'(k));
            rdaddr();
            rd(fn[k], 1'b1);
            rd(mem[fa[k]], 1'b0);
            u_smb_host.stop();
        end
        setptr(rnd_a());
        u_smb_host.hold_low(TMO + 50);
        wr(8'h3C, 1'b0);
        u_smb_host.stop();
        // Bytes cut short by START and by STOP
        a = rnd_a();
        setptr(a);
        u_smb_host.put(8'h5A, 4, k_ack);
        u_smb_host.start();
        wr({me, 1'b0}, 1'b1);
        wr(a, 1'b1);
        u_smb_host.put(8'hA5, 5, k_ack);
        u_smb_host.stop();
        mem[8'h20] = 8'hFF;
        setptr(8'h20);
        rdaddr();
        nd = n_done;
        u_smb_host.get(4, 1'b0);
        u_smb_host.stop();
        chk(16'(n_done - nd), 16'h0000);
        repeat (50) @(posedge clock);
        chk(16'(wq.size()), 16'h0000);
        chk(16'(rq.size()), 16'h0000);
        end_of_test();
    end

    initial begin
        #4_000_000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
